// [hdl/mfi_map.svh]
// Purpose: Offsets, field positions, reset values and counts of the block
// Assumes: 3-bit word addresses, 8-bit register data
// Notes: Included by both design files
`ifndef MFI_MAP_SVH
`define MFI_MAP_SVH
`define MFI_ADDR_CTRL_A 3'h0
`define MFI_ADDR_GROUP0 3'h1
`define MFI_ADDR_GROUP1 3'h2
`define MFI_ADDR_RTC 3'h3
`define MFI_ADDR_EVT_STAT 3'h4
`define MFI_ADDR_EVT_CLR 3'h5
`define MFI_ADDR_EVT_EN 3'h6
// Control register A fields
`define MFI_GIE_BIT 0
`define MFI_G0EN_BIT 1
`define MFI_G1EN_BIT 2
`define MFI_G0F_BIT 4
`define MFI_G1F_BIT 5
// Group 0 control fields
`define MFI_SIMEN_BIT 0
`define MFI_CRFEN_BIT 1
`define MFI_SERIAL_IF_REQUEST_FLAG_BIT 4
`define MFI_CRFF_BIT 5
// Group 1 control fields
`define MFI_ADEN_BIT 0
`define MFI_RTCEN_BIT 1
`define MFI_TBEN_BIT 2
`define MFI_ADF_BIT 4
`define MFI_RTCF_BIT 5
`define MFI_TBF_BIT 6
// Divider select field and event bits
`define MFI_RTC_SEL_MSB 2
`define MFI_EVT_TAKE0 0
`define MFI_EVT_TAKE1 1
`define MFI_EVT_RTC 2
`define MFI_EVT_TB 3
`define MFI_EVT_BLOCKED 4
`define MFI_EVT_W 5
// Vectors, exponents and reset values
`define MFI_VEC_GROUP0 8'h14
`define MFI_VEC_GROUP1 8'h18
`define MFI_VEC_NONE 8'h00
`define MFI_RTC_MIN_EXP 4'h8
`define MFI_TB_MIN_EXP 4'hC
`define MFI_SYSDIV_LAST 2'h3
`define MFI_RST_BYTE 8'h00
`define MFI_RST_SEL 3'h0
`define MFI_RST_EVT 5'h00
`endif

// [hdl/mfi_pkg.sv]
// Purpose: Types shared by the interrupt controller files
// Assumes: Nothing beyond the map header
// Notes: Sub-clock source is chosen at build time
package mfi_pkg;
  typedef enum logic [2:0] {
    FS_XTAL = 3'b001,
    FS_LIRC = 3'b010,
    FS_SYSDIV4 = 3'b100
  } fs_src_t;
  typedef logic [7:0] byte_t;
  typedef logic [2:0] addr_t;
endpackage : mfi_pkg

// [hdl/pow2_divider.sv]
// Purpose: Power-of-two divider of a tick stream
// Assumes: tick_i is a one-cycle enable in the clock domain
// Notes: ovf_o pulses once every 2^exp_i ticks
`timescale 1ns/1ps
`default_nettype none
`include "mfi_map.svh"
module pow2_divider #(
  parameter int WIDTH = 15
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Tick and ratio
  input wire logic tick_i,
  input wire logic [3:0] exp_i,
  // Overflow pulse
  output logic ovf_o
);
  logic [WIDTH:0] cnt;
  logic [WIDTH:0] mask;
  logic wrap;

  // Compare with >= so a smaller ratio written mid-count wraps on its next tick
  assign mask = ((WIDTH+1)'(1) << exp_i) - (WIDTH+1)'(1);
  assign wrap = tick_i && (cnt >= mask);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt <= '0;
      ovf_o <= 1'b0;
    end else begin
      ovf_o <= wrap;
      if (wrap) begin
        cnt <= '0;
      end else if (tick_i) begin
        cnt <= cnt + (WIDTH+1)'(1);
      end
    end
  end

  ovf_wrap_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ovf_o |-> cnt == '0) else $error("overflow without counter wrap");
endmodule : pow2_divider
`default_nettype wire

// [hdl/multi_function_irq_ctrl.sv]
// Purpose: Two shared interrupt groups, RTC and time base dividers
// Assumes: Source events are one-cycle pulses synchronous to CLK_I
// Notes: Service takes place only on SERVICE_SLOT_I pulses from the core
`timescale 1ns/1ps
`default_nettype none
`include "mfi_map.svh"
// Functional notes
// - Conversion done sets its flag; vectors 18H with global, own, group1 enables.
// - Group taken when global, group enable and group flag set; 014H/018H.
// - Taking a group clears its group flag and global enable, not sources.
// - No group taken while return stack is full; request stays pending.
// - Serial byte done or address match sets serial flag; group0, 14H.
// - Either sensor counter overflow sets sensor flag; group0, vector 14H.
// - RTC divider overflow sets RTC flag; group1, vector 18H.
// - RTC divider ratio is 2^8 to 2^15 by a three-bit field.
// - Build option picks sub-clock: crystal, internal oscillator, sysclk/4.
// - Time base overflow sets time base flag; group1, vector 18H.
// - Time base period is sub-clock over 2^12 to 2^15, build option.
// - Request flags stay set despite disabled enables until cleared.
// - Any source request wakes the processor from power-down.
// - Taking an interrupt pushes only the program counter.
// - Group0 ranks above group1; both below external and timer sources.
// - Global enable cleared means nothing is taken; flags still record.
module multi_function_irq_ctrl
  import mfi_pkg::*;
#(
  parameter mfi_pkg::fs_src_t FS_SRC = mfi_pkg::FS_XTAL,
  parameter logic [1:0] TB_SEL = 2'h0
) (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_B_I,
  // Register port
  input wire mfi_pkg::addr_t ADDR_I,
  input wire mfi_pkg::byte_t WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output mfi_pkg::byte_t RDATA_O,
  // Peripheral events
  input wire logic CONV_DONE_I,
  input wire logic SIM_XFER_DONE_I,
  input wire logic SIM_ADDR_MATCH_I,
  input wire logic CRF_OVF_A_I,
  input wire logic CRF_OVF_B_I,
  // Sub-clock ticks
  input wire logic XTAL_TICK_I,
  input wire logic LIRC_TICK_I,
  // Core sequencer
  input wire logic SERVICE_SLOT_I,
  input wire logic STACK_FULL_I,
  input wire logic HIGHER_PEND_I,
  output logic TAKE_O,
  output logic PUSH_PC_O,
  output mfi_pkg::byte_t VECTOR_O,
  output logic WAKE_O,
  // Event interrupt
  output logic IRQ_O
);
  import mfi_pkg::*;

  function automatic logic hit(input addr_t a, input addr_t off);
    hit = (a == off);
  endfunction : hit

  // Control state
  logic global_irq_enable;
  logic group0_irq_enable;
  logic group1_irq_enable;
  logic group0_request_flag;
  logic group1_request_flag;
  logic serial_if_irq_enable;
  logic sensor_conv_irq_enable;
  logic serial_if_request_flag;
  logic sensor_conv_request_flag;
  logic conv_done_irq_enable;
  logic rtc_irq_enable;
  logic timebase_irq_enable;
  logic conv_done_flag;
  logic rtc_request_flag;
  logic timebase_request_flag;
  logic [2:0] rtc_divider_control;
  logic [`MFI_EVT_W-1:0] evt_status;
  logic [`MFI_EVT_W-1:0] evt_enable;
  logic [1:0] sys_div;

  // Write decode
  wire wr_a = WR_I && hit(ADDR_I, `MFI_ADDR_CTRL_A);
  wire wr_g0 = WR_I && hit(ADDR_I, `MFI_ADDR_GROUP0);
  wire wr_g1 = WR_I && hit(ADDR_I, `MFI_ADDR_GROUP1);
  wire wr_rtc = WR_I && hit(ADDR_I, `MFI_ADDR_RTC);
  wire wr_clr = WR_I && hit(ADDR_I, `MFI_ADDR_EVT_CLR);
  wire wr_en = WR_I && hit(ADDR_I, `MFI_ADDR_EVT_EN);

  // Sub-clock selection
  wire sysdiv_tick = (sys_div == `MFI_SYSDIV_LAST);
  wire fs_tick = (FS_SRC == FS_XTAL) ? XTAL_TICK_I :
                 (FS_SRC == FS_LIRC) ? LIRC_TICK_I : sysdiv_tick;

  wire [3:0] rtc_exp = `MFI_RTC_MIN_EXP + {1'b0, rtc_divider_control};
  wire [3:0] tb_exp = `MFI_TB_MIN_EXP + {2'b00, TB_SEL};
  wire rtc_ovf;
  wire tb_ovf;

  pow2_divider #(.WIDTH(15)) rtc_div (
    .clk_i(CLK_I),
    .rst_b_i(RST_B_I),
    .tick_i(fs_tick),
    .exp_i(rtc_exp),
    .ovf_o(rtc_ovf)
  );

  pow2_divider #(.WIDTH(15)) tb_div (
    .clk_i(CLK_I),
    .rst_b_i(RST_B_I),
    .tick_i(fs_tick),
    .exp_i(tb_exp),
    .ovf_o(tb_ovf)
  );

  // Source events
  wire sim_evt = SIM_XFER_DONE_I || SIM_ADDR_MATCH_I;
  wire crf_evt = CRF_OVF_A_I || CRF_OVF_B_I;
  wire g0_set = (sim_evt && serial_if_irq_enable) ||
                (crf_evt && sensor_conv_irq_enable);
  wire g1_set = (CONV_DONE_I && conv_done_irq_enable) ||
                (rtc_ovf && rtc_irq_enable) ||
                (tb_ovf && timebase_irq_enable);

  // Service decision
  wire avail = global_irq_enable && !STACK_FULL_I && !HIGHER_PEND_I;
  wire pend0 = group0_irq_enable && group0_request_flag;
  wire pend1 = group1_irq_enable && group1_request_flag;
  wire take0 = SERVICE_SLOT_I && avail && pend0;
  wire take1 = SERVICE_SLOT_I && avail && pend1 && !pend0;
  wire blocked = SERVICE_SLOT_I && global_irq_enable && STACK_FULL_I &&
                 (pend0 || pend1);

  // Flag next values: set wins over any clear
  wire next_g0f = g0_set || (group0_request_flag && !take0 &&
                  !(wr_a && !WDATA_I[`MFI_G0F_BIT]));
  wire next_g1f = g1_set || (group1_request_flag && !take1 &&
                  !(wr_a && !WDATA_I[`MFI_G1F_BIT]));
  wire next_gie = wr_a ? WDATA_I[`MFI_GIE_BIT] :
                  (global_irq_enable && !take0 && !take1);
  wire next_serial_if_request_flag = sim_evt || (serial_if_request_flag &&
                   !(wr_g0 && !WDATA_I[`MFI_SERIAL_IF_REQUEST_FLAG_BIT]));
  wire next_crff = crf_evt || (sensor_conv_request_flag &&
                   !(wr_g0 && !WDATA_I[`MFI_CRFF_BIT]));
  wire next_adf = CONV_DONE_I || (conv_done_flag &&
                  !(wr_g1 && !WDATA_I[`MFI_ADF_BIT]));
  wire next_rtcf = rtc_ovf || (rtc_request_flag &&
                   !(wr_g1 && !WDATA_I[`MFI_RTCF_BIT]));
  wire next_tbf = tb_ovf || (timebase_request_flag &&
                  !(wr_g1 && !WDATA_I[`MFI_TBF_BIT]));

  wire [`MFI_EVT_W-1:0] evt_in = {blocked, tb_ovf, rtc_ovf, take1, take0};
  wire [`MFI_EVT_W-1:0] clr_mask = wr_clr ? WDATA_I[`MFI_EVT_W-1:0] : '0;
  wire [`MFI_EVT_W-1:0] next_evt = evt_in | (evt_status & ~clr_mask);

  wire next_wake = next_serial_if_request_flag || next_crff || next_adf || next_rtcf ||
                   next_tbf;
  wire [7:0] next_vector = take0 ? `MFI_VEC_GROUP0 :
                           take1 ? `MFI_VEC_GROUP1 : VECTOR_O;

  // Read mux
  wire [7:0] rd_a = {2'b00, group1_request_flag, group0_request_flag,
                     1'b0, group1_irq_enable, group0_irq_enable,
                     global_irq_enable};
  wire [7:0] rd_g0 = {2'b00, sensor_conv_request_flag,
                      serial_if_request_flag, 2'b00,
                      sensor_conv_irq_enable, serial_if_irq_enable};
  wire [7:0] rd_g1 = {1'b0, timebase_request_flag, rtc_request_flag,
                      conv_done_flag, 1'b0, timebase_irq_enable,
                      rtc_irq_enable, conv_done_irq_enable};
  wire [7:0] rd_sel =
    hit(ADDR_I, `MFI_ADDR_CTRL_A) ? rd_a :
    hit(ADDR_I, `MFI_ADDR_GROUP0) ? rd_g0 :
    hit(ADDR_I, `MFI_ADDR_GROUP1) ? rd_g1 :
    hit(ADDR_I, `MFI_ADDR_RTC) ? {5'h00, rtc_divider_control} :
    hit(ADDR_I, `MFI_ADDR_EVT_STAT) ? {3'h0, evt_status} :
    hit(ADDR_I, `MFI_ADDR_EVT_EN) ? {3'h0, evt_enable} : `MFI_RST_BYTE;
  wire [7:0] next_rdata = RD_I ? rd_sel : `MFI_RST_BYTE;

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      global_irq_enable <= 1'b0;
      group0_request_flag <= 1'b0;
      group1_request_flag <= 1'b0;
      serial_if_request_flag <= 1'b0;
      sensor_conv_request_flag <= 1'b0;
      conv_done_flag <= 1'b0;
      rtc_request_flag <= 1'b0;
      timebase_request_flag <= 1'b0;
    end else begin
      global_irq_enable <= next_gie;
      group0_request_flag <= next_g0f;
      group1_request_flag <= next_g1f;
      serial_if_request_flag <= next_serial_if_request_flag;
      sensor_conv_request_flag <= next_crff;
      conv_done_flag <= next_adf;
      rtc_request_flag <= next_rtcf;
      timebase_request_flag <= next_tbf;
    end
  end

  // Enable bits and RTC divider select, written whole
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      group0_irq_enable <= 1'b0;
      group1_irq_enable <= 1'b0;
      serial_if_irq_enable <= 1'b0;
      sensor_conv_irq_enable <= 1'b0;
      conv_done_irq_enable <= 1'b0;
      rtc_irq_enable <= 1'b0;
      timebase_irq_enable <= 1'b0;
      rtc_divider_control <= `MFI_RST_SEL;
    end else begin
      if (wr_a) begin
        group0_irq_enable <= WDATA_I[`MFI_G0EN_BIT];
        group1_irq_enable <= WDATA_I[`MFI_G1EN_BIT];
      end
      if (wr_g0) begin
        serial_if_irq_enable <= WDATA_I[`MFI_SIMEN_BIT];
        sensor_conv_irq_enable <= WDATA_I[`MFI_CRFEN_BIT];
      end
      if (wr_g1) begin
        conv_done_irq_enable <= WDATA_I[`MFI_ADEN_BIT];
        rtc_irq_enable <= WDATA_I[`MFI_RTCEN_BIT];
        timebase_irq_enable <= WDATA_I[`MFI_TBEN_BIT];
      end
      if (wr_rtc) begin
        rtc_divider_control <= WDATA_I[`MFI_RTC_SEL_MSB:0];
      end
    end
  end

  // Outputs, events and system divider
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      evt_status <= `MFI_RST_EVT;
      evt_enable <= `MFI_RST_EVT;
      sys_div <= 2'h0;
      RDATA_O <= `MFI_RST_BYTE;
      TAKE_O <= 1'b0;
      PUSH_PC_O <= 1'b0;
      VECTOR_O <= `MFI_VEC_NONE;
      WAKE_O <= 1'b0;
      IRQ_O <= 1'b0;
    end else begin
      evt_status <= next_evt;
      if (wr_en) begin
        evt_enable <= WDATA_I[`MFI_EVT_W-1:0];
      end
      sys_div <= sys_div + 2'h1;
      RDATA_O <= next_rdata;
      TAKE_O <= take0 || take1;
      // Only the return address goes to the stack; no context save
      PUSH_PC_O <= take0 || take1;
      VECTOR_O <= next_vector;
      WAKE_O <= next_wake;
      IRQ_O <= |(next_evt & (wr_en ? WDATA_I[`MFI_EVT_W-1:0] : evt_enable));
    end
  end

  // Checks
  take_gate_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    TAKE_O |-> $past(global_irq_enable) &&
      (($past(group0_irq_enable) && $past(group0_request_flag)) ||
       ($past(group1_irq_enable) && $past(group1_request_flag))))
    else $error("group taken without enables and flag");

  stack_full_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    (STACK_FULL_I && SERVICE_SLOT_I) |=> !TAKE_O &&
      (group0_request_flag || !$past(group0_request_flag) ||
       $past(wr_a)))
    else $error("interrupt taken or lost with stack full");

  gie_off_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
    !global_irq_enable |=> !TAKE_O)
    else $error("interrupt taken with global enable off");

  service_clear_a: assert property (
    @(posedge CLK_I) disable iff (!RST_B_I)
    (take0 && !wr_a && !g0_set) |=> !global_irq_enable &&
      !group0_request_flag && TAKE_O && PUSH_PC_O)
    else $error("service did not clear group flag and enable");

  group1_clear_a: assert property (
    @(posedge CLK_I) disable iff (!RST_B_I)
    (take1 && !wr_a && !g1_set) |=> !global_irq_enable &&
      !group1_request_flag && TAKE_O && PUSH_PC_O)
    else $error("service did not clear group1 flag and enable");

  source_stay_a: assert property (
    @(posedge CLK_I) disable iff (!RST_B_I)
    (take1 && conv_done_flag && !wr_g1) |=> conv_done_flag)
    else $error("service cleared a source flag");

  source_keep_a: assert property (
    @(posedge CLK_I) disable iff (!RST_B_I)
    (serial_if_request_flag && !wr_g0) |=> serial_if_request_flag)
    else $error("serial flag lost without software clear");

  record_off_a: assert property (
    @(posedge CLK_I) disable iff (!RST_B_I)
    (!global_irq_enable && CONV_DONE_I) |=> conv_done_flag)
    else $error("flag not recorded with global enable off");

  vector_prio_a: assert property (
    @(posedge CLK_I) disable iff (!RST_B_I)
    (SERVICE_SLOT_I && avail && pend0 && pend1)
      |=> TAKE_O && VECTOR_O == `MFI_VEC_GROUP0)
    else $error("group0 lost priority or wrong vector");

  vector_g1_a: assert property (
    @(posedge CLK_I) disable iff (!RST_B_I)
    take1 |=> VECTOR_O == `MFI_VEC_GROUP1)
    else $error("group1 vector wrong");

  rtc_flag_a: assert property (
    @(posedge CLK_I) disable iff (!RST_B_I)
    rtc_ovf |=> rtc_request_flag)
    else $error("rtc overflow did not set its flag");

  // Sensor case: no serial event arrives while group0 is clear
  group_gate_a: assert property (
    @(posedge CLK_I) disable iff (!RST_B_I)
    (crf_evt && !sensor_conv_irq_enable && !sim_evt &&
     !group0_request_flag) |=> !group0_request_flag &&
      sensor_conv_request_flag)
    else $error("disabled source raised group flag");

  // The neighbour flag is kept only when its own bit is written as one
  zero_clear_a: assert property (
    @(posedge CLK_I) disable iff (!RST_B_I)
    (wr_g1 && !WDATA_I[`MFI_ADF_BIT] && WDATA_I[`MFI_RTCF_BIT] &&
     !CONV_DONE_I && !rtc_ovf && rtc_request_flag) |=>
      !conv_done_flag && rtc_request_flag)
    else $error("zero write did not clear only its flag");

  wake_a: assert property (
    @(posedge CLK_I) disable iff (!RST_B_I)
    (CONV_DONE_I || tb_ovf) |=> WAKE_O)
    else $error("source request did not wake");

  rtc_ratio_a: assert property (
    @(posedge CLK_I) disable iff (!RST_B_I)
    rtc_exp >= `MFI_RTC_MIN_EXP)
    else $error("rtc ratio below range");
endmodule : multi_function_irq_ctrl
`default_nettype wire

// [verification/core_seq_model.sv]
// Purpose: Core sequencer model: service slots and return stack depth
// Assumes: push_pc_i is a one-cycle pulse per taken interrupt
// Notes: Slow mode offers a slot only every eighth cycle
`timescale 1ns/1ps
`default_nettype none
module core_seq_model #(
  parameter int DEPTH = 6
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Bench controls
  input wire logic slow_i,
  input wire logic pop_i,
  // Design side
  input wire logic push_pc_i,
  output logic slot_o,
  output logic full_o
);
  logic [3:0] depth;
  logic [2:0] phase;
  // Only the return address goes on the stack
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      depth <= 4'h0;
      phase <= 3'h0;
    end else begin
      phase <= phase + 3'h1;
      depth <= depth + 4'(push_pc_i) - 4'(pop_i && depth != 4'h0);
    end
  end
  // Full stack blocks service until a pop
  assign full_o = (depth == 4'(DEPTH));
  assign slot_o = rst_b_i && (!slow_i || phase == 3'h0);
endmodule : core_seq_model
`default_nettype wire

// [verification/multi_function_interrupt_ctrl_test.sv]
// Purpose: Self-checking bench of the shared interrupt groups
// Assumes: Crystal sub-clock, time base ratio 2^12
// Notes: Sub-clock ticks run every cycle to keep divider tests short
`timescale 1ns/1ps
`default_nettype none
`include "mfi_map.svh"
module multi_function_interrupt_ctrl_test;
  import mfi_pkg::*;
  logic clk, rst_b, wr, rd, xtick, hpend, slow, pop;
  logic slot, full, take, push, wake, irq;
  logic [4:0] ev;
  addr_t addr;
  byte_t wdata, rdata, vec;
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;

  multi_function_irq_ctrl #(.FS_SRC(FS_XTAL), .TB_SEL(2'h0)) uut (
    .CLK_I(clk), .RST_B_I(rst_b), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .CONV_DONE_I(ev[0]),
    .SIM_XFER_DONE_I(ev[1]), .SIM_ADDR_MATCH_I(ev[2]),
    .CRF_OVF_A_I(ev[3]), .CRF_OVF_B_I(ev[4]), .XTAL_TICK_I(xtick),
    .LIRC_TICK_I(1'b0), .SERVICE_SLOT_I(slot), .STACK_FULL_I(full),
    .HIGHER_PEND_I(hpend), .TAKE_O(take), .PUSH_PC_O(push),
    .VECTOR_O(vec), .WAKE_O(wake), .IRQ_O(irq));
  core_seq_model #(.DEPTH(6)) core (.clk_i(clk), .rst_b_i(rst_b),
    .slow_i(slow), .pop_i(pop), .push_pc_i(push), .slot_o(slot),
    .full_o(full));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Whole run needs about 33300 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 45000) begin
      error_cnt++;
      final_report();
    end
  end

  task automatic final_report();
    if (error_cnt == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic bus_wr(input addr_t a, input byte_t d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : bus_wr

  // Read data stand only in the cycle after the strobe
  task automatic bus_rd(input addr_t a, input byte_t exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask : bus_rd

  task automatic ev_pulse(input logic [4:0] m);
    ev <= m;
    @(posedge clk);
    ev <= 5'h00;
    #1;
  endtask : ev_pulse

  task automatic tick(input int n);
    xtick <= 1'b1;
    repeat (n) @(posedge clk);
    xtick <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask : tick

  task automatic cycle();
    @(posedge clk);
    #1;
  endtask : cycle

  task automatic no_take(input int n);
    repeat (n) begin
      cycle();
      chk({7'h00, take}, 8'h00);
    end
  endtask : no_take

  task automatic wait_take(input byte_t v);
    int n;
    n = 0;
    while (take !== 1'b1 && n < 40) begin
      cycle();
      n++;
    end
    chk({7'h00, take}, 8'h01);
    chk({7'h00, push}, 8'h01);
    chk(vec, v);
    cycle();
    chk({7'h00, take}, 8'h00);
  endtask : wait_take

  initial begin
    rst_b = 1'b0;
    {wr, rd, xtick, hpend, slow, pop} = 6'h00;
    ev = 5'h00;
    addr = 3'h0;
    wdata = 8'h00;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    cycle();
    // Unmapped and read-only places ignore writes
    bus_wr(3'h7, 8'hFF);
    bus_wr(`MFI_ADDR_EVT_STAT, 8'hFF);
    for (int i = 0; i < 8; i++) bus_rd(addr_t'(i), 8'h00);
    chk(vec, 8'h00);
    chk({6'h00, wake, irq}, 8'h00);
    // Dividers: slowest real time clock ratio, then the fastest
    bus_wr(`MFI_ADDR_RTC, 8'h07);
    tick(4095);
    bus_rd(`MFI_ADDR_GROUP1, 8'h00);
    tick(1);
    bus_rd(`MFI_ADDR_GROUP1, 8'h40);
    chk({7'h00, wake}, 8'h01);
    tick(28671);
    bus_rd(`MFI_ADDR_GROUP1, 8'h40);
    tick(1);
    bus_rd(`MFI_ADDR_GROUP1, 8'h60);
    bus_rd(`MFI_ADDR_EVT_STAT, 8'h0C);
    bus_wr(`MFI_ADDR_GROUP1, 8'h20);
    bus_rd(`MFI_ADDR_GROUP1, 8'h20);
    bus_wr(`MFI_ADDR_GROUP1, 8'h00);
    bus_wr(`MFI_ADDR_RTC, 8'h00);
    bus_wr(`MFI_ADDR_EVT_CLR, 8'h1F);
    tick(255);
    bus_rd(`MFI_ADDR_GROUP1, 8'h00);
    tick(1);
    bus_rd(`MFI_ADDR_GROUP1, 8'h20);
    bus_wr(`MFI_ADDR_GROUP1, 8'h00);
    bus_wr(`MFI_ADDR_EVT_CLR, 8'h1F);
    cycle();
    chk({7'h00, wake}, 8'h00);
    // Group 0 sources: serial enabled, sensor disabled
    bus_wr(`MFI_ADDR_GROUP0, 8'h01);
    ev_pulse(5'h08);
    bus_rd(`MFI_ADDR_GROUP0, 8'h21);
    bus_rd(`MFI_ADDR_CTRL_A, 8'h00);
    bus_wr(`MFI_ADDR_GROUP0, 8'h01);
    bus_rd(`MFI_ADDR_GROUP0, 8'h01);
    ev_pulse(5'h10);
    bus_rd(`MFI_ADDR_GROUP0, 8'h21);
    ev_pulse(5'h04);
    bus_rd(`MFI_ADDR_GROUP0, 8'h31);
    bus_rd(`MFI_ADDR_CTRL_A, 8'h10);
    bus_wr(`MFI_ADDR_GROUP0, 8'h21);
    bus_rd(`MFI_ADDR_GROUP0, 8'h21);
    ev_pulse(5'h02);
    bus_rd(`MFI_ADDR_GROUP0, 8'h31);
    bus_wr(`MFI_ADDR_GROUP0, 8'h30);
    bus_rd(`MFI_ADDR_GROUP0, 8'h30);
    bus_wr(`MFI_ADDR_GROUP1, 8'h01);
    ev_pulse(5'h01);
    bus_rd(`MFI_ADDR_GROUP1, 8'h11);
    bus_rd(`MFI_ADDR_CTRL_A, 8'h30);
    // Both groups pending: global off, then higher source busy
    bus_wr(`MFI_ADDR_CTRL_A, 8'h36);
    no_take(6);
    hpend <= 1'b1;
    bus_wr(`MFI_ADDR_CTRL_A, 8'h37);
    no_take(6);
    hpend <= 1'b0;
    wait_take(8'h14);
    bus_rd(`MFI_ADDR_CTRL_A, 8'h26);
    bus_rd(`MFI_ADDR_GROUP0, 8'h30);
    no_take(6);
    slow <= 1'b1;
    bus_wr(`MFI_ADDR_CTRL_A, 8'h27);
    wait_take(8'h18);
    bus_rd(`MFI_ADDR_CTRL_A, 8'h06);
    bus_rd(`MFI_ADDR_GROUP1, 8'h11);
    // Event interrupt: raise, mask, clear
    bus_wr(`MFI_ADDR_EVT_EN, 8'h01);
    bus_rd(`MFI_ADDR_EVT_STAT, 8'h03);
    chk({7'h00, irq}, 8'h01);
    bus_wr(`MFI_ADDR_EVT_EN, 8'h00);
    cycle();
    chk({7'h00, irq}, 8'h00);
    bus_wr(`MFI_ADDR_EVT_EN, 8'h01);
    bus_wr(`MFI_ADDR_EVT_CLR, 8'h01);
    cycle();
    chk({7'h00, irq}, 8'h00);
    bus_rd(`MFI_ADDR_EVT_STAT, 8'h02);
    bus_rd(`MFI_ADDR_EVT_CLR, 8'h00);
    // Fill the six-deep stack, then a request must wait for a pop
    slow <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      ev_pulse(5'h01);
      bus_wr(`MFI_ADDR_CTRL_A, 8'h37);
      wait_take(8'h18);
    end
    bus_wr(`MFI_ADDR_EVT_CLR, 8'h1F);
    ev_pulse(5'h01);
    bus_wr(`MFI_ADDR_CTRL_A, 8'h37);
    no_take(8);
    bus_rd(`MFI_ADDR_CTRL_A, 8'h27);
    bus_rd(`MFI_ADDR_EVT_STAT, 8'h10);
    pop <= 1'b1;
    cycle();
    pop <= 1'b0;
    wait_take(8'h18);
    bus_wr(`MFI_ADDR_GROUP0, 8'h00);
    bus_wr(`MFI_ADDR_GROUP1, 8'h00);
    bus_wr(`MFI_ADDR_CTRL_A, 8'h00);
    cycle();
    chk({7'h00, wake}, 8'h00);
    final_report();
  end
endmodule : multi_function_interrupt_ctrl_test
`default_nettype wire
